// ### include/bkreg_pkg.sv
// shared constants and types for the buck regulator register bank
package bkreg_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] ADDR_CHIP_INFO = 8'h02;
  localparam logic [7:0] ADDR_FAULT     = 8'h03;
  localparam logic [7:0] ADDR_LEVEL     = 8'h11;
  localparam logic [7:0] ADDR_CFG       = 8'h12;
  localparam logic [7:0] ADDR_FEAT      = 8'h13;

  // ==========================================================
  // field positions
  localparam int CFG_SW_EN   = 7;
  localparam int CFG_SOFT_DISCHARGE_BIT   = 6;
  localparam int CFG_SLEW_HI = 5;
  localparam int CFG_SLEW_LO = 4;
  localparam int CFG_MODE_HI = 3;
  localparam int CFG_MODE_LO = 2;
  localparam int CFG_CTRL    = 0;
  localparam int FEAT_OC_HI  = 7;
  localparam int FEAT_OC_LO  = 6;
  localparam int FEAT_AUX    = 5;
  localparam int FEAT_EN_OR  = 4;
  localparam int FAULT_OC    = 0;

  // ==========================================================
  // values after reset and encodings
  localparam logic [7:0] CFG_RST   = 8'h80;
  localparam logic [7:0] FEAT_RST  = 8'h00;
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [7:0] FAULT_RST = 8'h00;
  localparam logic [1:0] OC_HICCUP = 2'h0;
  localparam logic [1:0] OC_LATCH  = 2'h1;
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2a;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SLEW_STEP_NS  = 8000;
  localparam int SLEW_STEP_CYC = SLEW_STEP_NS * 1000 / CLK_PERIOD_PS;
  localparam int HICCUP_NS     = 20000;
  localparam int HICCUP_CYC    = HICCUP_NS * 1000 / CLK_PERIOD_PS;

  // ==========================================================
  // serial slave states
  typedef enum logic [3:0] {
    I2C_IDLE  = 4'h0,
    I2C_ADDR  = 4'h1,
    I2C_AACK  = 4'h2,
    I2C_PTR   = 4'h3,
    I2C_PACK  = 4'h4,
    I2C_WDATA = 4'h5,
    I2C_WACK  = 4'h6,
    I2C_RDATA = 4'h7,
    I2C_RACK  = 4'h8
  } bkreg_i2c_state_t;

endpackage : bkreg_pkg

// ### hw/bkreg_i2c_slave.sv
// serial two-wire slave: address match, register pointer, byte reads and writes
`timescale 1ns/1ps
module bkreg_i2c_slave #(
  parameter logic [6:0] SLAVE_ADDR = bkreg_pkg::SLAVE_ADDR_DEF
) (
  input  wire logic       i_ref_clk,  // system clock
  input  wire logic       i_rst_n,    // async reset, active low
  input  wire logic       i_scl,      // synchronised serial clock
  input  wire logic       i_sda,      // synchronised serial data
  input  wire logic [7:0] i_rd_data,  // read value at o_ptr
  output logic            o_sda_oe_n, // low pulls data line low
  output logic            o_wr_pulse, // one-cycle write strobe
  output logic [7:0]      o_wr_addr,  // write register address
  output logic [7:0]      o_wr_data,  // write data
  output logic            o_rd_load,  // one cycle, i_rd_data taken
  output logic [7:0]      o_ptr       // current register pointer
);

  bkreg_pkg::bkreg_i2c_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next, wa_reg, wa_next, wd_reg, wd_next;
  logic       rw_reg, rw_next, mack_reg, mack_next, oe_reg, oe_next, wr_reg, wr_next;
  logic       scl_d_reg, sda_d_reg, rise, fall, start, stop, load;

  // ==========================================================
  // bus condition detection
  assign rise  = i_scl & ~scl_d_reg;
  assign fall  = ~i_scl & scl_d_reg;
  assign start = i_scl & scl_d_reg & sda_d_reg & ~i_sda;
  assign stop  = i_scl & scl_d_reg & ~sda_d_reg & i_sda;

  // ==========================================================
  // next-state of the byte engine
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    sh_next   = sh_reg;
    ptr_next  = ptr_reg;
    rw_next   = rw_reg;
    mack_next = mack_reg;
    oe_next   = oe_reg;
    wa_next   = wa_reg;
    wd_next   = wd_reg;
    wr_next   = 1'b0;
    load      = 1'b0;
    if (start) begin
      st_next  = bkreg_pkg::I2C_ADDR;
      cnt_next = 4'h0;
      oe_next  = 1'b1;
    end else if (stop) begin
      st_next = bkreg_pkg::I2C_IDLE;
      oe_next = 1'b1;
    end else if (rise) begin
      case (st_reg)
        bkreg_pkg::I2C_ADDR, bkreg_pkg::I2C_PTR, bkreg_pkg::I2C_WDATA: begin
          sh_next  = {sh_reg[6:0], i_sda};
          cnt_next = 4'(cnt_reg + 4'h1);
        end
        bkreg_pkg::I2C_RACK: mack_next = ~i_sda;
        default: ;
      endcase
    end else if (fall) begin
      case (st_reg)
        bkreg_pkg::I2C_ADDR: begin
          if (cnt_reg == 4'h8) begin
            if (sh_reg[7:1] == SLAVE_ADDR) begin
              st_next = bkreg_pkg::I2C_AACK;
              oe_next = 1'b0;
              rw_next = sh_reg[0];
            end else begin
              st_next = bkreg_pkg::I2C_IDLE;
            end
          end
        end
        bkreg_pkg::I2C_AACK: begin
          cnt_next = 4'h0;
          if (rw_reg) begin
            load = 1'b1;
          end else begin
            st_next = bkreg_pkg::I2C_PTR;
            oe_next = 1'b1;
          end
        end
        bkreg_pkg::I2C_PTR: begin
          if (cnt_reg == 4'h8) begin
            ptr_next = sh_reg;
            oe_next  = 1'b0;
            st_next  = bkreg_pkg::I2C_PACK;
          end
        end
        bkreg_pkg::I2C_PACK, bkreg_pkg::I2C_WACK: begin
          oe_next  = 1'b1;
          cnt_next = 4'h0;
          st_next  = bkreg_pkg::I2C_WDATA;
        end
        bkreg_pkg::I2C_WDATA: begin
          if (cnt_reg == 4'h8) begin
            wr_next  = 1'b1;
            wa_next  = ptr_reg;
            wd_next  = sh_reg;
            ptr_next = 8'(ptr_reg + 8'h01);
            oe_next  = 1'b0;
            st_next  = bkreg_pkg::I2C_WACK;
          end
        end
        bkreg_pkg::I2C_RDATA: begin
          if (cnt_reg == 4'h7) begin
            oe_next = 1'b1;
            st_next = bkreg_pkg::I2C_RACK;
          end else begin
            oe_next  = sh_reg[6];
            sh_next  = {sh_reg[6:0], 1'b0};
            cnt_next = 4'(cnt_reg + 4'h1);
          end
        end
        bkreg_pkg::I2C_RACK: begin
          cnt_next = 4'h0;
          if (mack_reg) begin
            load = 1'b1;
          end else begin
            st_next = bkreg_pkg::I2C_IDLE;
            oe_next = 1'b1;
          end
        end
        default: st_next = bkreg_pkg::I2C_IDLE;
      endcase
    end
    // whole byte taken at once, first bit driven
    if (load) begin
      st_next  = bkreg_pkg::I2C_RDATA;
      sh_next  = i_rd_data;
      oe_next  = i_rd_data[7];
      ptr_next = 8'(ptr_reg + 8'h01);
    end
  end

  // ==========================================================
  // byte engine registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg    <= bkreg_pkg::I2C_IDLE;
      cnt_reg   <= 4'h0;
      sh_reg    <= 8'h00;
      ptr_reg   <= 8'h00;
      rw_reg    <= 1'b0;
      mack_reg  <= 1'b0;
      oe_reg    <= 1'b1;
      wa_reg    <= 8'h00;
      wd_reg    <= 8'h00;
      wr_reg    <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      ptr_reg   <= ptr_next;
      rw_reg    <= rw_next;
      mack_reg  <= mack_next;
      oe_reg    <= oe_next;
      wa_reg    <= wa_next;
      wd_reg    <= wd_next;
      wr_reg    <= wr_next;
      scl_d_reg <= i_scl;
      sda_d_reg <= i_sda;
    end
  end

  assign o_sda_oe_n = oe_reg;
  assign o_wr_pulse = wr_reg;
  assign o_wr_addr  = wa_reg;
  assign o_wr_data  = wd_reg;
  assign o_rd_load  = load;
  assign o_ptr      = ptr_reg;

endmodule : bkreg_i2c_slave

// ### hw/bkreg_top.sv
// buck regulator control and status register bank behind a two-wire serial port
// Contract
// - The identification register at 0x02 shows family, revision and variant and ignores writes.
// - Writing the level register at 0x11 ramps the output target upward at the configured slew rate.
// - A level below the present target is applied at once without controlled slewing.
// - Each fault bit at 0x03 is set by its event, held, and cleared when the host reads it.
// - The configuration register at 0x12 is read and written whole in one access.
// - Configuration bit 7 at its inhibit value disables the converter whatever the enable pin does.
// - With bit 6 set, the converter disabled by bit 7 and supply present, the discharge path is on.
// - Configuration bits 5:4 select the upward slew rate.
// - Configuration bits 3:2 select auto pulse-frequency, forced PWM or forced bypass.
// - Configuration bit 0 selects the first or second type of error amplifier compensation.
// - The feature register at 0x13 is read and written whole in one access.
// - Feature bits 7:6 choose the over-current reaction, one of them hiccup retry.
// - Feature bit 4 turns the enable pin into a push-button that latches the converter on.
// - With feature bit 4 clear, the converter is off while the enable pin is low and on while it is high.
`timescale 1ns/1ps
module bkreg_top #(
  parameter logic [6:0] SLAVE_ADDR   = bkreg_pkg::SLAVE_ADDR_DEF,
  parameter logic [3:0] FAMILY_CODE  = 4'h5, // arbitrary value
  parameter logic [1:0] REV_CODE     = 2'h1, // arbitrary value
  parameter logic [1:0] VARIANT_CODE = 2'h2  // arbitrary value
) (
  input  wire logic       i_ref_clk,     // 200 MHz clock
  input  wire logic       i_rst_n,       // async reset, active low
  input  wire logic       i_scl,         // serial clock pin
  input  wire logic       i_sda,         // serial data pin, input side
  input  wire logic       i_en_pin,      // enable pin
  input  wire logic       i_vin_ok,      // input supply present
  input  wire logic [7:0] i_fault_evt,   // fault event levels, bit 0 over-current
  output logic            o_sda,         // serial data output value, always low
  output logic            o_sda_oe_n,    // low pulls data line low
  output logic [7:0]      o_target_level,// ramped output target code
  output logic            o_conv_en,     // converter enabled
  output logic            o_discharge_en,// output discharge resistor on
  output logic [1:0]      o_op_mode,     // operating mode field
  output logic            o_ctrl_type,   // compensation type
  output logic [1:0]      o_oc_policy,   // over-current policy field
  output logic            o_aux_switch,  // auxiliary switch bit
  output logic [7:0]      o_fault_flags  // sticky fault flags
);

  localparam logic [7:0] CHIP_INFO = {FAMILY_CODE, REV_CODE, VARIANT_CODE};

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // ==========================================================
  // pin synchronisers, stage one read only by stage two
  logic [11:0] sync1_reg, sync2_reg;
  logic [7:0]  fault_d_reg;
  logic        en_d_reg;
  logic        scl_s, sda_s, en_s, vin_s;
  logic [7:0]  fault_s;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg   <= 12'h003;
      sync2_reg   <= 12'h003;
      fault_d_reg <= 8'h00;
      en_d_reg    <= 1'b0;
    end else begin
      sync1_reg   <= {i_fault_evt, i_vin_ok, i_en_pin, i_sda, i_scl};
      sync2_reg   <= sync1_reg;
      fault_d_reg <= fault_s;
      en_d_reg    <= en_s;
    end
  end

  assign scl_s   = sync2_reg[0];
  assign sda_s   = sync2_reg[1];
  assign en_s    = sync2_reg[2];
  assign vin_s   = sync2_reg[3];
  assign fault_s = sync2_reg[11:4];

  // ==========================================================
  // serial slave
  logic       wr_pulse, rd_load;
  logic [7:0] wr_addr, wr_data, ptr, rd_mux;

  bkreg_i2c_slave #(.SLAVE_ADDR(SLAVE_ADDR)) u_slave (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_scl      (scl_s),
    .i_sda      (sda_s),
    .i_rd_data  (rd_mux),
    .o_sda_oe_n (o_sda_oe_n),
    .o_wr_pulse (wr_pulse),
    .o_wr_addr  (wr_addr),
    .o_wr_data  (wr_data),
    .o_rd_load  (rd_load),
    .o_ptr      (ptr)
  );

  // ==========================================================
  // register state
  logic [7:0]  level_reg, level_next, target_reg, target_next;
  logic [7:0]  cfg_reg, cfg_next, feat_reg, feat_next, flag_reg, flag_next;
  logic [11:0] step_reg, step_next, hic_reg, hic_next;
  logic        push_reg, push_next, lock_reg, lock_next;
  logic        conv_reg, conv_next, dis_reg, dis_next;
  logic [11:0] step_len;
  logic [7:0]  evt_rise;
  logic        en_rise, oc_rise, en_src;

  // read side, whole register per access
  always_comb begin
    case (ptr)
      bkreg_pkg::ADDR_CHIP_INFO: rd_mux = CHIP_INFO;
      bkreg_pkg::ADDR_FAULT:     rd_mux = flag_reg;
      bkreg_pkg::ADDR_LEVEL:     rd_mux = level_reg;
      bkreg_pkg::ADDR_CFG:       rd_mux = cfg_reg;
      bkreg_pkg::ADDR_FEAT:      rd_mux = feat_reg;
      default:                   rd_mux = 8'h00;
    endcase
  end

  assign evt_rise = fault_s & ~fault_d_reg;
  assign en_rise  = en_s & ~en_d_reg;
  assign oc_rise  = evt_rise[bkreg_pkg::FAULT_OC];
  assign step_len = 12'(bkreg_pkg::SLEW_STEP_CYC) >> cfg_reg[bkreg_pkg::CFG_SLEW_HI:bkreg_pkg::CFG_SLEW_LO];

  // over-current policy field of a feature value
  function automatic logic [1:0] oc_field(input logic [7:0] f_val);
    return f_val[bkreg_pkg::FEAT_OC_HI:bkreg_pkg::FEAT_OC_LO];
  endfunction : oc_field

  // next values of registers, ramp and enable logic
  always_comb begin
    level_next  = level_reg;
    target_next = target_reg;
    step_next   = step_reg;
    cfg_next    = cfg_reg;
    feat_next   = feat_reg;
    hic_next    = hic_reg;
    lock_next   = lock_reg;
    push_next   = push_reg;
    // writes to the identification address fall through here
    if (wr_pulse && wr_addr == bkreg_pkg::ADDR_CFG) begin
      cfg_next  = wr_data;
      lock_next = 1'b0;
    end
    if (wr_pulse && wr_addr == bkreg_pkg::ADDR_FEAT) begin
      feat_next = wr_data;
    end
    // upward ramp one code per interval, downward jump
    if (wr_pulse && wr_addr == bkreg_pkg::ADDR_LEVEL) begin
      level_next = wr_data;
      step_next  = 12'(step_len - 12'h001);
      if (wr_data < target_reg) begin
        target_next = wr_data;
      end
    end else if (target_reg < level_reg) begin
      if (step_reg == 12'h000) begin
        target_next = 8'(target_reg + 8'h01);
        step_next   = 12'(step_len - 12'h001);
      end else begin
        step_next = 12'(step_reg - 12'h001);
      end
    end else begin
      step_next = 12'(step_len - 12'h001);
    end
    // fault flags, a new event wins over the read clear
    if (rd_load && ptr == bkreg_pkg::ADDR_FAULT) begin
      flag_next = evt_rise;
    end else begin
      flag_next = flag_reg | evt_rise;
    end
    // over-current reaction
    if (oc_rise && oc_field(feat_reg) == bkreg_pkg::OC_HICCUP) begin
      hic_next = 12'(bkreg_pkg::HICCUP_CYC);
    end else if (hic_reg != 12'h000) begin
      hic_next = 12'(hic_reg - 12'h001);
    end
    if (oc_rise && oc_field(feat_reg) == bkreg_pkg::OC_LATCH) begin
      lock_next = 1'b1;
    end
    // push-button latch, dropped by software disable or level mode
    if (!feat_reg[bkreg_pkg::FEAT_EN_OR] || !cfg_reg[bkreg_pkg::CFG_SW_EN]) begin
      push_next = 1'b0;
    end else if (en_rise) begin
      push_next = 1'b1;
    end
    en_src    = feat_reg[bkreg_pkg::FEAT_EN_OR] ? push_reg : en_s;
    conv_next = cfg_reg[bkreg_pkg::CFG_SW_EN] & en_src & (hic_reg == 12'h000) & ~lock_reg;
    dis_next  = cfg_reg[bkreg_pkg::CFG_SOFT_DISCHARGE_BIT] & ~cfg_reg[bkreg_pkg::CFG_SW_EN] & vin_s;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_reg  <= bkreg_pkg::LEVEL_RST;
      target_reg <= bkreg_pkg::LEVEL_RST;
      step_reg   <= 12'h000;
      cfg_reg    <= bkreg_pkg::CFG_RST;
      feat_reg   <= bkreg_pkg::FEAT_RST;
      flag_reg   <= bkreg_pkg::FAULT_RST;
      hic_reg    <= 12'h000;
      lock_reg   <= 1'b0;
      push_reg   <= 1'b0;
      conv_reg   <= 1'b0;
      dis_reg    <= 1'b0;
    end else begin
      level_reg  <= level_next;
      target_reg <= target_next;
      step_reg   <= step_next;
      cfg_reg    <= cfg_next;
      feat_reg   <= feat_next;
      flag_reg   <= flag_next;
      hic_reg    <= hic_next;
      lock_reg   <= lock_next;
      push_reg   <= push_next;
      conv_reg   <= conv_next;
      dis_reg    <= dis_next;
    end
  end

  // ==========================================================
  // outputs
  assign o_sda          = 1'b0;
  assign o_target_level = target_reg;
  assign o_conv_en      = conv_reg;
  assign o_discharge_en = dis_reg;
  assign o_op_mode      = cfg_reg[bkreg_pkg::CFG_MODE_HI:bkreg_pkg::CFG_MODE_LO];
  assign o_ctrl_type    = cfg_reg[bkreg_pkg::CFG_CTRL];
  assign o_oc_policy    = feat_reg[bkreg_pkg::FEAT_OC_HI:bkreg_pkg::FEAT_OC_LO];
  assign o_aux_switch   = feat_reg[bkreg_pkg::FEAT_AUX];
  assign o_fault_flags  = flag_reg;

  // ==========================================================
  // checks
  a_info_read_only: assert property (
    (ptr == bkreg_pkg::ADDR_CHIP_INFO) |-> (rd_mux == CHIP_INFO))
    else $error("identification read value wrong");
  a_ramp_single_step: assert property (
    (target_reg != $past(target_reg)) && ($past(target_reg) < $past(level_reg)) && !$past(wr_pulse)
    |-> (target_reg == 8'($past(target_reg) + 8'h01)))
    else $error("upward ramp step is not one code");
  a_fall_jumps: assert property (
    (wr_pulse && wr_addr == bkreg_pkg::ADDR_LEVEL && wr_data < target_reg) |=> (target_reg == $past(wr_data)))
    else $error("lower level not applied at once");
  a_flag_read_clear: assert property (
    (rd_load && ptr == bkreg_pkg::ADDR_FAULT && evt_rise == 8'h00) |=> (flag_reg == 8'h00))
    else $error("fault flags not cleared by read");
  a_flag_sets_holds: assert property (
    (evt_rise != 8'h00) |=> ((flag_reg & $past(evt_rise)) == $past(evt_rise)))
    else $error("fault event not latched");
  a_cfg_whole_write: assert property (
    (wr_pulse && wr_addr == bkreg_pkg::ADDR_CFG) |=> (cfg_reg == $past(wr_data)) && (rd_mux == cfg_reg || ptr != 8'h12))
    else $error("configuration write not whole");
  a_sw_inhibit: assert property (
    !cfg_reg[bkreg_pkg::CFG_SW_EN] |=> !o_conv_en)
    else $error("converter on while inhibited");
  a_discharge_on: assert property (
    (cfg_reg[bkreg_pkg::CFG_SOFT_DISCHARGE_BIT] && !cfg_reg[bkreg_pkg::CFG_SW_EN] && vin_s) [*2] |-> o_discharge_en)
    else $error("discharge path not connected");
  a_slew_spacing: assert property (
    (target_reg > $past(target_reg)) |-> ($past(step_reg) == 12'h000))
    else $error("ramp stepped before interval end");
  a_hiccup_off: assert property (
    (oc_rise && o_oc_policy == bkreg_pkg::OC_HICCUP) |=> ##1 (!o_conv_en) [*8])
    else $error("converter on during hiccup wait");
  a_level_enable: assert property (
    (!en_s && !feat_reg[bkreg_pkg::FEAT_EN_OR]) |=> !o_conv_en)
    else $error("converter on with enable pin low");

  // further identification, enable, ramp, discharge and policy checks
  a_info_ignores_wr: assert property (
    (wr_pulse && wr_addr == bkreg_pkg::ADDR_CHIP_INFO) |=> $stable(cfg_reg) && $stable(feat_reg) && $stable(level_reg))
    else $error("write to identification address changed state");
  a_target_bounded: assert property (
    target_reg <= level_reg)
    else $error("ramp target passed the set level");
  a_ramp_waits: assert property (
    (wr_pulse && wr_addr == bkreg_pkg::ADDR_LEVEL && wr_data >= target_reg) |=> $stable(target_reg))
    else $error("upward ramp stepped without waiting");
  a_discharge_off: assert property (
    cfg_reg[bkreg_pkg::CFG_SW_EN] |=> !o_discharge_en)
    else $error("discharge path on while enabled");
  a_latch_off: assert property (
    (oc_rise && o_oc_policy == bkreg_pkg::OC_LATCH) |=> ##1 !o_conv_en)
    else $error("converter on after latch-off event");
  a_flag_only: assert property (
    (oc_rise && o_oc_policy[1] && !lock_reg && hic_reg == 12'h000) |=> (!lock_reg && hic_reg == 12'h000))
    else $error("flag-only policy stopped the converter");
  a_push_latch: assert property (
    (feat_reg[bkreg_pkg::FEAT_EN_OR] && cfg_reg[bkreg_pkg::CFG_SW_EN] && en_rise) |=> push_reg)
    else $error("push-button press not latched");
  a_level_on: assert property (
    (en_s && !feat_reg[bkreg_pkg::FEAT_EN_OR] && cfg_reg[bkreg_pkg::CFG_SW_EN] && hic_reg == 12'h000 && !lock_reg)
    |=> o_conv_en)
    else $error("converter off with enable pin high");

endmodule : bkreg_top

// ### sim/bkreg_host_model.sv
// serial bus master model that reaches the register bank
`timescale 1ns/1ps
module bkreg_host_model #(
  parameter logic [6:0] SLAVE_ADDR = bkreg_pkg::SLAVE_ADDR_DEF
) (
  input  wire logic i_ref_clk, // pacing clock
  input  wire logic i_sda,     // resolved data line
  output logic      o_scl,     // serial clock, idle high
  output logic      o_sda      // data drive, 1 releases
);
  // ==========================================================
  // bus idles released, clock stands high between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // waits a number of reference cycles
  task automatic tk(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : tk
  // start or repeated start: data falls while clock high
  task automatic start_cond();
    tk(3);
    o_sda <= 1'b1;
    tk(3);
    o_scl <= 1'b1;
    tk(4);
    o_sda <= 1'b0;
    tk(4);
    o_scl <= 1'b0;
  endtask : start_cond
  // stop: data rises while clock high
  task automatic stop_cond();
    tk(3);
    o_sda <= 1'b0;
    tk(3);
    o_scl <= 1'b1;
    tk(4);
    o_sda <= 1'b1;
    tk(4);
  endtask : stop_cond
  // one 64 ns bit slot, data set in low phase, sampled in high phase
  task automatic bit_slot(input logic b, output logic r);
    #12 o_sda <= b;
    #20 o_scl <= 1'b1;
    #20 r = i_sda;
    #12 o_scl <= 1'b0;
  endtask : bit_slot
  // eight bits msb first, then the acknowledge slot
  task automatic byte_xfer(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_slot(tx[i], rx[i]);
    end
    bit_slot(ack_out, ack);
  endtask : byte_xfer
  // address, register pointer, one data byte
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic       k1, k2, k3;
    start_cond();
    byte_xfer({SLAVE_ADDR, 1'b0}, 1'b1, rx, k1);
    byte_xfer(a, 1'b1, rx, k2);
    byte_xfer(d, 1'b1, rx, k3);
    stop_cond();
    ok = !(k1 | k2 | k3);
  endtask : write_reg
  // pointer write, repeated start, one byte read then nack
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic       k1, k2, k3, k4;
    start_cond();
    byte_xfer({SLAVE_ADDR, 1'b0}, 1'b1, rx, k1);
    byte_xfer(a, 1'b1, rx, k2);
    start_cond();
    byte_xfer({SLAVE_ADDR, 1'b1}, 1'b1, rx, k3);
    byte_xfer(8'hff, 1'b1, d, k4);
    stop_cond();
    ok = !(k1 | k2 | k3);
  endtask : read_reg
endmodule : bkreg_host_model

// ### sim/bkreg_top_tb_top.sv
// self-checking bench of the regulator register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin failures++; $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module bkreg_top_tb_top;
  logic       i_ref_clk, i_rst_n, scl, sda_m, sda_w, i_en_pin, i_vin_ok;
  logic [7:0] i_fault_evt, o_target_level, o_fault_flags;
  logic       o_sda, o_sda_oe_n, o_conv_en, o_discharge_en, o_ctrl_type, o_aux_switch;
  logic [1:0] o_op_mode, o_oc_policy;
  int         failures, checks_done, cycles;
  // open-drain data line with pull-up
  assign sda_w = sda_m & (o_sda_oe_n ? 1'b1 : o_sda);
  bkreg_top u_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_w), .i_en_pin(i_en_pin),
    .i_vin_ok(i_vin_ok), .i_fault_evt(i_fault_evt), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
    .o_target_level(o_target_level), .o_conv_en(o_conv_en), .o_discharge_en(o_discharge_en),
    .o_op_mode(o_op_mode), .o_ctrl_type(o_ctrl_type), .o_oc_policy(o_oc_policy),
    .o_aux_switch(o_aux_switch), .o_fault_flags(o_fault_flags));
  bkreg_host_model u_host (.i_ref_clk(i_ref_clk), .i_sda(sda_w), .o_scl(scl), .o_sda(sda_m));
  // ==========================================================
  // clock and hang guard
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic tk(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : tk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_host.write_reg(a, d, ok);
    `CHK(ok, 1'b1)
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_host.read_reg(a, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, exp)
  endtask : rd
  task automatic end_of_test();
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  // ==========================================================
  // main sequence
  initial begin
    i_rst_n = 1'b0;
    sda_m = 1'b1;
    i_en_pin = 1'b0;
    i_vin_ok = 1'b1;
    i_fault_evt = 8'h00;
    tk(2);
    i_rst_n <= 1'b1;
    tk(4);
    rd(8'h12, 8'h80);
    rd(8'h13, 8'h00);
    wr(8'h02, 8'hff);
    rd(8'h02, 8'h56);
    rd(8'h20, 8'h00);
    // every mode and both compensation types, slew field ends at 3
    for (int m = 0; m < 4; m++) begin
      wr(8'h12, {4'b1011, m[1:0], 1'b0, m[0]});
      rd(8'h12, {4'b1011, m[1:0], 1'b0, m[0]});
      `CHK(o_op_mode, m[1:0])
      `CHK(o_ctrl_type, m[0])
    end
    // enable pin, software inhibit, discharge
    i_en_pin <= 1'b1;
    tk(8);
    `CHK(o_conv_en, 1'b1)
    i_en_pin <= 1'b0;
    tk(8);
    `CHK(o_conv_en, 1'b0)
    i_en_pin <= 1'b1;
    wr(8'h12, 8'h7d);
    `CHK(o_conv_en, 1'b0)
    `CHK(o_discharge_en, 1'b1)
    i_vin_ok <= 1'b0;
    tk(8);
    `CHK(o_discharge_en, 1'b0)
    i_vin_ok <= 1'b1;
    wr(8'h12, 8'hbd);
    `CHK(o_conv_en, 1'b1)
    `CHK(o_discharge_en, 1'b0)
    // push-button enable, flag-only policy
    wr(8'h13, 8'hf0);
    rd(8'h13, 8'hf0);
    `CHK(o_oc_policy, 2'h3)
    `CHK(o_aux_switch, 1'b1)
    `CHK(o_conv_en, 1'b0)
    i_en_pin <= 1'b0;
    tk(8);
    i_en_pin <= 1'b1;
    tk(8);
    i_en_pin <= 1'b0;
    tk(8);
    `CHK(o_conv_en, 1'b1)
    // sticky fault flags cleared by reading
    i_fault_evt <= 8'h09;
    tk(8);
    i_fault_evt <= 8'h00;
    tk(8);
    `CHK(o_fault_flags, 8'h09)
    `CHK(o_conv_en, 1'b1)
    rd(8'h03, 8'h09);
    `CHK(o_fault_flags, 8'h00)
    rd(8'h03, 8'h00);
    // hiccup retry after 4000 cycles, then latch-off
    i_en_pin <= 1'b1;
    wr(8'h13, 8'h00);
    i_fault_evt <= 8'h01;
    tk(100);
    `CHK(o_conv_en, 1'b0)
    tk(4000);
    `CHK(o_conv_en, 1'b1)
    i_fault_evt <= 8'h00;
    wr(8'h13, 8'h40);
    i_fault_evt <= 8'h01;
    tk(4100);
    `CHK(o_conv_en, 1'b0)
    i_fault_evt <= 8'h00;
    wr(8'h12, 8'hbd);
    `CHK(o_conv_en, 1'b1)
    // upward ramp one code per 200 cycles at slew field 3, fall at once
    wr(8'h11, 8'h05);
    `CHK(o_target_level, 8'h00)
    tk(400);
    `CHK(o_target_level, 8'h02)
    tk(700);
    `CHK(o_target_level, 8'h05)
    rd(8'h11, 8'h05);
    wr(8'h11, 8'h02);
    `CHK(o_target_level, 8'h02)
    end_of_test();
  end
endmodule : bkreg_top_tb_top
